// ---- pkg/usb_pm_pkg.sv ----
// package for the usb power management and endpoint sizing block
// assumes a single 200 MHz core clock and a synchronous line-state input
package usb_pm_pkg;
	// ------------------------------------------------------------------
	// clock and timing
	// ------------------------------------------------------------------
	localparam int unsigned CLK_KHZ        = 200000;
	localparam int unsigned IDLE_SUSP_US   = 3000;   // 3 ms of idle
	localparam int unsigned SE0_RESET_US   = 68;     // about 68 us of se0
	localparam int unsigned RST_HOLD_US    = 3500;   // 3.5 ms, least
	localparam int unsigned RESUME_K_US    = 2000;   // about 2 ms
	localparam int unsigned ISO_FRAME_US   = 1000;   // 1 ms frame
	localparam int unsigned IDLE_SUSP_CYC  = IDLE_SUSP_US * CLK_KHZ / 1000;
	localparam int unsigned SE0_RESET_CYC  = SE0_RESET_US * CLK_KHZ / 1000;
	localparam int unsigned RST_HOLD_CYC   = RST_HOLD_US * CLK_KHZ / 1000 + 1;
	localparam int unsigned RESUME_K_CYC   = RESUME_K_US * CLK_KHZ / 1000;
	localparam int unsigned ISO_FRAME_CYC  = ISO_FRAME_US * CLK_KHZ / 1000;
	localparam int unsigned CNT_W          = 20;

	// ------------------------------------------------------------------
	// endpoint sizing
	// ------------------------------------------------------------------
	localparam logic [10:0] ISO_MAX_PAYLOAD = 11'h3ff;   // 1023 bytes
	localparam int unsigned DUAL_BUF_BYTES  = 2048;
	localparam logic [1:0]  BE_LOW_BYTE     = 2'h1;      // final odd byte

	// ------------------------------------------------------------------
	// register map, word offsets on the plain port
	// ------------------------------------------------------------------
	localparam logic [3:0] OFS_EP_MAX_SIZE = 4'h0;
	localparam logic [3:0] OFS_EP_STATUS   = 4'h1;
	localparam logic [3:0] OFS_EP_COMMAND  = 4'h2;
	localparam logic [3:0] OFS_PM_STATUS   = 4'h3;
	localparam logic [10:0] RST_MAX_SIZE   = 11'h040;
	localparam logic [15:0] RST_EP_STATUS  = 16'h0000;
	localparam logic [3:0] CMD_EP_REINIT   = 4'h1;
	localparam logic [3:0] CMD_EP_DISABLE  = 4'h2;
	localparam logic [3:0] CMD_EP_PKT_END  = 4'h3;

	// line states seen from the phy
	localparam logic [1:0] LS_SE0  = 2'h0;
	localparam logic [1:0] LS_J    = 2'h1;
	localparam logic [1:0] LS_K    = 2'h2;

	typedef enum logic [2:0] {
		ST_ACTIVE  = 3'b000,
		ST_RESET   = 3'b001,
		ST_SUSPEND = 3'b010,
		ST_WAKEREQ = 3'b011,
		ST_RESUMEK = 3'b100
	} pm_state_e;

	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [3:0]  addr;
		logic [31:0] wdata;
	} reg_req_s;

	typedef struct packed {
		pm_state_e   st;
		logic [CNT_W-1:0] idle_cnt;
		logic [CNT_W-1:0] se0_cnt;
		logic [CNT_W-1:0] tmr;
		logic        usb_reset;
		logic        suspend_n;
		logic        drive_k;
		logic        direct_mode;
		logic [10:0] max_size;
		logic [15:0] ep_status;
		logic [3:0]  last_cmd;
		logic        size_err;
		logic [31:0] rdata;
	} pm_regs_s;
endpackage

// ---- core/usb_pm_core.sv ----
// usb device bus power management and endpoint size guard
// assumes line state, wakeup and the register port are synchronous to clk;
// the wakeup path to suspend_n is combinational so it works with clk held
//
// The implementer's own choices: the address map and the strobed register port.
module usb_pm_core
	import usb_pm_pkg::*;
#(
	parameter int unsigned IDLE_CYC  = IDLE_SUSP_CYC,
	parameter int unsigned RST_CYC   = RST_HOLD_CYC,
	parameter int unsigned RESUME_CYC = RESUME_K_CYC,
	parameter int unsigned SE0_CYC   = SE0_RESET_CYC
) (
	input  wire logic        clk,
	input  wire logic        arst_n,
	input  wire logic [1:0]  line_state,
	input  wire logic        wakeup,
	input  wire logic        ep_is_tx,
	input  wire logic        ep_is_iso,
	input  wire reg_req_s    req,
	output logic [31:0]      rdata,
	output logic             usb_reset,
	output logic             suspend_n,
	output logic             resume_k_oe,
	output logic             size_err
);
	pm_regs_s r_ff;
	pm_regs_s nxt_r;

	// ------------------------------------------------------------------
	// outputs
	// ------------------------------------------------------------------
	// wakeup bypasses the flop so suspend lifts with clk stopped
	assign suspend_n   = r_ff.suspend_n | wakeup;
	assign usb_reset   = r_ff.usb_reset;
	assign resume_k_oe = r_ff.drive_k;
	assign size_err    = r_ff.size_err;
	assign rdata       = r_ff.rdata;

	// ------------------------------------------------------------------
	// next state
	// ------------------------------------------------------------------
	always_comb begin
		nxt_r = r_ff;
		nxt_r.rdata = 32'h0000_0000;
		// idle is j with no edge; any other line state is activity
		if (line_state == LS_J)
			nxt_r.idle_cnt = (r_ff.idle_cnt == CNT_W'(IDLE_CYC)) ?
				r_ff.idle_cnt : r_ff.idle_cnt + CNT_W'(1);
		else
			nxt_r.idle_cnt = '0;
		if (line_state == LS_SE0)
			nxt_r.se0_cnt = (r_ff.se0_cnt == CNT_W'(SE0_CYC)) ?
				r_ff.se0_cnt : r_ff.se0_cnt + CNT_W'(1);
		else
			nxt_r.se0_cnt = '0;
		case (r_ff.st)
			ST_ACTIVE: begin
				// se0 wins over idle so reset and suspend never overlap
				// fires once per se0 run, on the cycle the count fills
				if (line_state == LS_SE0 &&
					r_ff.se0_cnt == CNT_W'(SE0_CYC - 1)) begin
					nxt_r.st        = ST_RESET;
					nxt_r.usb_reset = 1'b1;
					nxt_r.tmr       = '0;
				end else if (r_ff.idle_cnt == CNT_W'(IDLE_CYC)) begin
					nxt_r.st        = ST_SUSPEND;
					nxt_r.suspend_n = 1'b0;
				end
			end
			ST_RESET: begin
				// hold past 3.5 ms, then drop even while the host still drives se0
				if (r_ff.tmr != CNT_W'(RST_CYC))
					nxt_r.tmr = r_ff.tmr + CNT_W'(1);
				else begin
					// host keeps se0 past this point, so drop here
					nxt_r           = '0;
					nxt_r.st        = ST_ACTIVE;
					nxt_r.suspend_n = 1'b1;
					nxt_r.max_size  = RST_MAX_SIZE;
					nxt_r.ep_status = RST_EP_STATUS;
					nxt_r.direct_mode = 1'b0;
					// keep the se0 run saturated so the host's long
					// reset tail does not start a second bus reset
					nxt_r.se0_cnt = (line_state == LS_SE0) ?
						CNT_W'(SE0_CYC) : '0;
				end
			end
			ST_SUSPEND: begin
				// host resume is k on the line
				if (line_state == LS_K) begin
					nxt_r.st        = ST_ACTIVE;
					nxt_r.suspend_n = 1'b1;
				end else if (line_state == LS_SE0 &&
					r_ff.se0_cnt == CNT_W'(SE0_CYC - 1)) begin
					nxt_r.st        = ST_RESET;
					nxt_r.suspend_n = 1'b1;
					nxt_r.usb_reset = 1'b1;
					nxt_r.tmr       = '0;
				end else if (wakeup) begin
					// first clock edge after restore starts the resume
					nxt_r.st        = ST_RESUMEK;
					nxt_r.suspend_n = 1'b1;
					nxt_r.drive_k   = 1'b1;
					nxt_r.tmr       = '0;
				end
			end
			ST_RESUMEK: begin
				// own k is bus activity: idle restarts after resume
				nxt_r.idle_cnt = '0;
				if (r_ff.tmr == CNT_W'(RESUME_CYC - 1)) begin
					nxt_r.st      = ST_ACTIVE;
					nxt_r.drive_k = 1'b0;
				end else
					nxt_r.tmr = r_ff.tmr + CNT_W'(1);
			end
			default: nxt_r.st = ST_ACTIVE;
		endcase

		// register writes: ignored during reset, lost anyway at its end
		if (req.wr && r_ff.st != ST_RESET) begin
			case (req.addr)
				OFS_EP_MAX_SIZE: begin
					nxt_r.max_size = req.wdata[10:0];
					// odd size on a direct transmit endpoint is flagged
					nxt_r.size_err = req.wdata[0] & ep_is_tx &
						r_ff.direct_mode;
					if (ep_is_iso && req.wdata[10:0] > ISO_MAX_PAYLOAD)
						nxt_r.size_err = 1'b1;
				end
				OFS_EP_STATUS: begin
					nxt_r.ep_status   = req.wdata[15:0];
					nxt_r.direct_mode = req.wdata[16];
				end
				OFS_EP_COMMAND: nxt_r.last_cmd = req.wdata[3:0];
				default: ;
			endcase
		end

		// read data valid the cycle after the strobe
		if (req.rd) begin
			case (req.addr)
				OFS_EP_MAX_SIZE: nxt_r.rdata = {21'h0, r_ff.max_size};
				OFS_EP_STATUS:   nxt_r.rdata = {15'h0, r_ff.direct_mode,
					r_ff.ep_status};
				OFS_EP_COMMAND:  nxt_r.rdata = {28'h0, r_ff.last_cmd};
				OFS_PM_STATUS:   nxt_r.rdata = {25'h0, r_ff.size_err,
					r_ff.drive_k, r_ff.suspend_n, r_ff.usb_reset,
					r_ff.st};
				default:         nxt_r.rdata = 32'h0000_0000;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// state register; no edges means no access while clk is stopped
	// ------------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			r_ff           <= '0;
			r_ff.suspend_n <= 1'b1;
			r_ff.max_size  <= RST_MAX_SIZE;
		end else
			r_ff <= nxt_r;
	end
endmodule

// ---- sim/usb_pm_props.sv ----
// checker for the usb power management block, bound to its top module
// assumes one clock domain and the short counts handed on by the bind
module usb_pm_props
	import usb_pm_pkg::*;
#(
	parameter int unsigned IDLE_CYC   = 80,
	parameter int unsigned RST_CYC    = 60,
	parameter int unsigned RESUME_CYC = 20,
	parameter int unsigned SE0_CYC    = 8
) (
	input wire logic       clk,
	input wire logic       arst_n,
	input wire logic [1:0] line_state,
	input wire logic       wakeup,
	input wire logic       ep_is_iso,
	input wire reg_req_s   req,
	input wire logic       usb_reset,
	input wire logic       suspend_n,
	input wire logic       resume_k_oe,
	input wire logic       size_err
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking @(posedge clk); endclocking
	default disable iff (!arst_n);
	int c [4];
	// -----------------------------------------------------------------
	// run lengths: se0, idle j, reset high, resume k high
	// -----------------------------------------------------------------
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			c <= '{default: 0};
		end else begin
			c[0] <= (line_state == LS_SE0) ? c[0] + 1 : 0;
			c[1] <= (line_state == LS_J) ? c[1] + 1 : 0;
			c[2] <= usb_reset ? c[2] + 1 : 0;
			c[3] <= resume_k_oe ? c[3] + 1 : 0;
		end
	end
	// remote wake while suspended
	sequence s_wake;
		!suspend_n ##1 wakeup;
	endsequence
	AST_RST_RISE: assert property ($rose(usb_reset) |-> c[0] >= SE0_CYC)
		else $error("bus reset raised on short se0");
	AST_RST_FALL: assert property ($fell(usb_reset) |-> c[2] >= RST_CYC)
		else $error("bus reset dropped too early");
	AST_SUSP: assert property ($fell(suspend_n) |-> c[1] >= IDLE_CYC)
		else $error("suspend entered on short idle");
	AST_EXCL: assert property (!(usb_reset && !suspend_n))
		else $error("reset and suspend together");
	AST_WAKE: assert property (wakeup |-> suspend_n)
		else $error("wakeup did not lift suspend");
	AST_K_START: assert property (s_wake |=> resume_k_oe)
		else $error("resume k not started");
	AST_K_LEN: assert property ($fell(resume_k_oe) |->
		c[3] >= RESUME_CYC && c[3] <= RESUME_CYC + 1)
		else $error("resume k length wrong");
	AST_ISO_CAP: assert property (req.wr &&
		req.addr == OFS_EP_MAX_SIZE && ep_is_iso && !usb_reset &&
		req.wdata[10:0] > ISO_MAX_PAYLOAD |=> size_err)
		else $error("oversize iso not flagged");
endmodule
bind usb_pm_core usb_pm_props #(.IDLE_CYC(IDLE_CYC), .RST_CYC(RST_CYC),
	.RESUME_CYC(RESUME_CYC), .SE0_CYC(SE0_CYC)) usb_pm_props_inst (.*);

// ---- sim/usb_host_model.sv ----
// host model: produces the line state the phy reports
// assumes go strobes are one clk cycle long
module usb_host_model
	import usb_pm_pkg::*;
#(
	parameter int HOLD = 180
) (
	input  wire logic       clk,
	input  wire logic       arst_n,
	input  wire logic       go_rst,
	input  wire logic       go_k,
	output logic [1:0]      line_state
);
	timeunit 1ns;
	timeprecision 100ps;
	int   cnt;
	logic k;
	// se0 held well past the device reset timer
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt <= 0;
			k <= 1'b0;
		end else if (go_rst || go_k) begin
			cnt <= HOLD;
			k <= go_k;
		end else if (cnt != 0) begin
			cnt <= cnt - 1;
		end
	end
	// resume k closes with one se0 cycle, then idle j
	assign line_state = (cnt == 0) ? LS_J : (k && cnt > 1) ? LS_K : LS_SE0;
endmodule

// ---- sim/usb_pm_core_bench.sv ----
// bench for the usb power management block with a host line model
// assumes short counts: idle 80, reset 60, resume 20, se0 8
module usb_pm_core_bench import usb_pm_pkg::*;;
	timeunit 1ns;
	timeprecision 100ps;
	logic        clk, arst_n, wakeup, ep_is_tx, ep_is_iso, go_rst, go_k;
	logic        usb_reset, suspend_n, resume_k_oe, size_err;
	logic [1:0]  line_state;
	logic [31:0] rdata, d;
	reg_req_s    req;
	int          n_mismatch = 0, tests_run = 0;
	usb_pm_core #(.IDLE_CYC(80), .RST_CYC(60), .RESUME_CYC(20), .SE0_CYC(8))
		usb_pm_core_inst (.*);
	usb_host_model #(.HOLD(180)) usb_host_model_inst (.*);
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end
	// -----------------------------------------------------------------
	// shared tasks
	// -----------------------------------------------------------------
	task report_and_stop;
		$display("mismatches %0d checks %0d", n_mismatch, tests_run);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task chk(input string n, input logic [31:0] e, input logic [31:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask
	function logic sig(int s);
		return s == 0 ? usb_reset : s == 1 ? suspend_n :
			s == 2 ? resume_k_oe : line_state == LS_J;
	endfunction
	// bounded wait, a hang ends the run
	task wt(input int s, input logic v);
		int i;
		for (i = 0; sig(s) !== v; i++) begin
			if (i > 500) begin
				chk("wait", 32'h1, 32'h0);
				report_and_stop();
			end
			@(posedge clk);
			#1;
		end
	endtask
	task wr(input logic [3:0] a, input logic [31:0] v);
		@(posedge clk) req <= '{1'b1, 1'b0, a, v};
		@(posedge clk) req <= '0;
	endtask
	task rd(input logic [3:0] a);
		@(posedge clk) req <= '{1'b0, 1'b1, a, 32'h0};
		@(posedge clk) req <= '0;
		#1 d = rdata;
	endtask
	task sz(input logic tx, input logic iso, input logic [10:0] s, input logic e);
		ep_is_tx <= tx;
		ep_is_iso <= iso;
		wr(OFS_EP_MAX_SIZE, {21'h0, s});
		#1 chk("size_err", {31'h0, e}, {31'h0, size_err});
	endtask
	// -----------------------------------------------------------------
	// scenarios
	// -----------------------------------------------------------------
	task t_reset;
		wr(OFS_EP_STATUS, 32'h0001_0005);
		@(posedge clk) go_rst <= 1'b1; // no dma partner to restart
		@(posedge clk) go_rst <= 1'b0;
		wt(0, 1'b1);
		wr(OFS_EP_MAX_SIZE, 32'h0000_0010); // written while reset high
		wt(0, 1'b0);
		rd(OFS_EP_MAX_SIZE);
		chk("max_size", {21'h0, RST_MAX_SIZE}, d);
		rd(OFS_EP_STATUS);
		chk("ep_status", 32'h0, d);
		wt(3, 1'b1);
		wr(OFS_EP_MAX_SIZE, 32'h0000_0020); // configure first
		wr(OFS_EP_COMMAND, {28'h0, CMD_EP_REINIT});
		rd(OFS_EP_COMMAND);
		chk("last_cmd", {28'h0, CMD_EP_REINIT}, d);
	endtask
	task t_size;
		wr(OFS_EP_STATUS, 32'h0001_0000);
		sz(1'b1, 1'b0, 11'h3ff, 1'b1);
		sz(1'b1, 1'b0, 11'h400, 1'b0);
		sz(1'b0, 1'b1, 11'h401, 1'b1);
		sz(1'b0, 1'b1, 11'h3ff, 1'b0);
		sz(1'b0, 1'b0, 11'h3ff, 1'b0);
		rd(4'hf);
		chk("unmapped", 32'h0, d);
	endtask
	task t_susp;
		int n;
		wt(1, 1'b0);
		chk("usb_reset", 32'h0, {31'h0, usb_reset});
		repeat (10) @(posedge clk);
		wakeup <= 1'b1;
		#1 chk("suspend_n", 32'h1, {31'h0, suspend_n});
		wt(2, 1'b1);
		wakeup <= 1'b0; // clock never stops here
		for (n = 0; resume_k_oe === 1'b1 && n < 100; n++)
			@(posedge clk) #1;
		chk("resume_len", 32'd20, n);
		wt(1, 1'b0);
		@(posedge clk) go_k <= 1'b1;
		@(posedge clk) go_k <= 1'b0;
		wt(1, 1'b1);
	endtask
	initial begin
		{arst_n, wakeup, ep_is_tx, ep_is_iso, go_rst, go_k} = '0;
		req = '0;
		repeat (12) @(posedge clk);
		arst_n <= 1'b1;
		t_reset();
		t_size();
		t_susp();
		report_and_stop();
	end
endmodule
